// file: design/ortx_top.sv
/*
 * octal registered bus transceiver with an avalon-mm capture log.
// Contract
// - two bidirectional eight-bit ports A and B, each with storage and tristate drive
// - rising capture clock loads its port value into that port's register
// - capture happens whatever the selects and enables are
// - port terminals are always sampled, even while the port drives
// - A-to-B enable low and B-to-A enable_n high isolate both ports
// - select low picks live opposite bus, high picks stored register
// - A-to-B enabled, B select low: B driven with inverted live A
// - B-to-A enabled, A select low: A driven with inverted live B
// - A-to-B enabled, B select high: B driven with inverted A register
// - B-to-A enabled, A select high: A driven with inverted B register
// - both enabled, both selects high: both ports driven from stored registers
// - driving B from A, both clocks: B register takes the driven B value
// - driving A from B, both clocks: A register takes the driven A value
// - both live and both enabled: outputs reinforce inputs and hold state
// - B drive depends only on A-to-B enable, A drive only on its enable
 * assumes all pins synchronous to clk_sys; the bus wire values come back on *_in.
 */
`timescale 1ns/1ps

// small flip-flop fifo, valid/ready on both sides
module ortx_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// honest flags straight from the count
	assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready && ce;
	assign pop = out_valid && out_ready && ce;

	// next pointers, count and storage
	always_comb begin
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wr_reg] = in_data;
			wr_next = ptr_inc(wr_reg);
		end
		if (pop) begin
			rd_next = ptr_inc(rd_reg);
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// storage needs no reset; only the pointers and the count define content
	always_ff @(posedge clk_sys) begin
		mem_reg <= mem_next;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	chk_fifo_no_overfill: assert property (@(posedge clk_sys) disable iff (rst)
		cnt_reg <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

////////////////////////////////////////////////////////////////////////////////

module ortx_top #(
	parameter int PORT_W = ortx_pkg::ORTX_PORT_W,
	parameter int LOG_DEPTH = ortx_pkg::ORTX_LOG_DEPTH
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// transceiver control pins
	input wire ortx_pkg::ortx_ctrl_t ctrl_pins,
	input wire logic a_capture_clock,
	input wire logic b_capture_clock,
	// port A as three signals
	input wire logic [PORT_W-1:0] a_in,
	output logic [PORT_W-1:0] a_out,
	output logic a_oe,
	// port B as three signals
	input wire logic [PORT_W-1:0] b_in,
	output logic [PORT_W-1:0] b_out,
	output logic b_oe,
	// capture log back-pressure
	output logic log_ready,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import ortx_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// transceiver state
	logic [PORT_W-1:0] a_store_reg, a_store_next;
	logic [PORT_W-1:0] b_store_reg, b_store_next;
	logic a_clk_prev_reg, a_clk_prev_next;
	logic b_clk_prev_reg, b_clk_prev_next;
	logic [PORT_W-1:0] a_out_reg, a_out_next, b_out_reg, b_out_next;
	logic a_oe_reg, a_oe_next, b_oe_reg, b_oe_next;
	logic a_rise, b_rise;

	// register bus state
	logic [1:0] ctrl_reg, ctrl_next;
	logic ovf_reg, ovf_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic log_ready_reg, log_ready_next;

	// log fifo wiring
	ortx_log_t log_in, log_out;
	logic log_in_valid, log_in_ready, log_out_valid, log_pop;
	logic bus_req, bus_take;

	assign a_rise = ce && a_capture_clock && !a_clk_prev_reg;
	assign b_rise = ce && b_capture_clock && !b_clk_prev_reg;

	// inverted data path shared by both directions
	function automatic logic [PORT_W-1:0] drive_value(input logic stored_sel,
		input logic [PORT_W-1:0] stored, input logic [PORT_W-1:0] live);
		drive_value = stored_sel ? ~stored : ~live;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// capture and drive: next values
	always_comb begin
		a_store_next = a_store_reg;
		b_store_next = b_store_reg;
		a_clk_prev_next = a_clk_prev_reg;
		b_clk_prev_next = b_clk_prev_reg;
		a_out_next = a_out_reg;
		b_out_next = b_out_reg;
		a_oe_next = a_oe_reg;
		b_oe_next = b_oe_reg;
		if (ce) begin
			a_clk_prev_next = a_capture_clock;
			b_clk_prev_next = b_capture_clock;
			// terminal value, own drive included, whatever the controls say
			if (a_rise) begin
				a_store_next = a_in;
			end
			if (b_rise) begin
				b_store_next = b_in;
			end
			// each side's drive follows only its own enable
			b_oe_next = ctrl_pins.a_to_b_drive_enable;
			a_oe_next = !ctrl_pins.b_to_a_drive_enable_n;
			b_out_next = drive_value(ctrl_pins.b_side_source_select,
				a_store_reg, a_in);
			a_out_next = drive_value(ctrl_pins.a_side_source_select,
				b_store_reg, b_in);
			// in live mode with both enabled a=~b and b=~a agree, so the loop holds
			// its state once other drivers release the wires
		end
	end

	// stored data has no reset: contents stay undefined after power-up
	always_ff @(posedge clk_sys) begin
		a_store_reg <= a_store_next;
		b_store_reg <= b_store_next;
		a_out_reg <= a_out_next;
		b_out_reg <= b_out_next;
	end

	// enables and edge detectors reset to isolation
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			a_clk_prev_reg <= 1'b1;
			b_clk_prev_reg <= 1'b1;
			a_oe_reg <= 1'b0;
			b_oe_reg <= 1'b0;
		end else begin
			a_clk_prev_reg <= a_clk_prev_next;
			b_clk_prev_reg <= b_clk_prev_next;
			a_oe_reg <= a_oe_next;
			b_oe_reg <= b_oe_next;
		end
	end

	assign a_out = a_out_reg;
	assign b_out = b_out_reg;
	assign a_oe = a_oe_reg;
	assign b_oe = b_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// capture log: one entry per cycle holding both ports' events
	assign log_in.a_hit = a_rise && ctrl_reg[ORTX_CTRL_LOG_A_BIT];
	assign log_in.b_hit = b_rise && ctrl_reg[ORTX_CTRL_LOG_B_BIT];
	assign log_in.a_val = a_in;
	assign log_in.b_val = b_in;
	assign log_in_valid = log_in.a_hit || log_in.b_hit;

	ortx_fifo #(
		.WIDTH(ORTX_LOG_W),
		.DEPTH(LOG_DEPTH)
	) u_log (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.in_valid(log_in_valid),
		.in_ready(log_in_ready),
		.in_data(log_in),
		.out_valid(log_out_valid),
		.out_ready(log_pop),
		.out_data(log_out)
	);

	////////////////////////////////////////////////////////////////////////
	// avalon slave: answer one cycle after the request, act on the taken edge
	assign bus_req = avs_read || avs_write;
	assign bus_take = bus_req && !wait_reg && ce;
	assign log_pop = bus_take && avs_read && (avs_address == ORTX_LOG_OFF);

	always_comb begin
		ctrl_next = ctrl_reg;
		ovf_next = ovf_reg;
		wait_next = wait_reg;
		rdata_next = rdata_reg;
		log_ready_next = log_ready_reg;
		if (ce) begin
			log_ready_next = log_in_ready;
			wait_next = !(bus_req && wait_reg);
			if (bus_req && wait_reg) begin
				rdata_next = 32'h0000_0000;
				if (avs_address == ORTX_CTRL_OFF) begin
					rdata_next[1:0] = ctrl_reg;
				end else if (avs_address == ORTX_STAT_OFF) begin
					rdata_next[ORTX_STAT_OVF_BIT] = ovf_reg;
					rdata_next[ORTX_STAT_NEMPTY_BIT] = log_out_valid;
					rdata_next[ORTX_STAT_A_OE_BIT] = a_oe_reg;
					rdata_next[ORTX_STAT_B_OE_BIT] = b_oe_reg;
					rdata_next[ORTX_STAT_A_LIVE_POS +: PORT_W] = a_in;
					rdata_next[ORTX_STAT_B_LIVE_POS +: PORT_W] = b_in;
				end else if (avs_address == ORTX_LOG_OFF) begin
					rdata_next[PORT_W-1:0] = log_out.a_val;
					rdata_next[ORTX_LOG_B_POS +: PORT_W] = log_out.b_val;
					rdata_next[ORTX_LOG_A_HIT_BIT] = log_out.a_hit;
					rdata_next[ORTX_LOG_B_HIT_BIT] = log_out.b_hit;
					rdata_next[ORTX_LOG_VALID_BIT] = log_out_valid;
				end else if (avs_address == ORTX_STORE_OFF) begin
					rdata_next[PORT_W-1:0] = a_store_reg;
					rdata_next[ORTX_STORE_B_POS +: PORT_W] = b_store_reg;
				end
			end
			// write-one clears overflow; a fresh loss in the same cycle wins
			if (bus_take && avs_write && avs_address == ORTX_CTRL_OFF) begin
				ctrl_next = avs_writedata[1:0];
			end
			if (bus_take && avs_write && avs_address == ORTX_STAT_OFF
				&& avs_writedata[ORTX_STAT_OVF_BIT]) begin
				ovf_next = 1'b0;
			end
			if (log_in_valid && !log_in_ready) begin
				ovf_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= ORTX_CTRL_RST;
			ovf_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			log_ready_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			ovf_reg <= ovf_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			log_ready_reg <= log_ready_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign log_ready = log_ready_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_a_edge;
		ce && !a_clk_prev_reg && a_capture_clock;
	endsequence

	sequence s_b_edge;
		ce && !b_clk_prev_reg && b_capture_clock;
	endsequence

	sequence s_no_edges_held;
		ce && !a_rise && !b_rise;
	endsequence

	chk_a_store_load: assert property (@(posedge clk_sys) disable iff (rst)
		s_a_edge |=> a_store_reg == $past(a_in)) else $error("A register missed capture");

	chk_b_store_load: assert property (@(posedge clk_sys) disable iff (rst)
		s_b_edge |=> b_store_reg == $past(b_in)) else $error("B register missed capture");

	chk_store_hold: assert property (@(posedge clk_sys) disable iff (rst)
		s_no_edges_held ##1 s_no_edges_held |=> a_store_reg === $past(a_store_reg)
		&& b_store_reg === $past(b_store_reg)) else $error("register changed without edge");

	chk_isolation_state: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !ctrl_pins.a_to_b_drive_enable && ctrl_pins.b_to_a_drive_enable_n
		|=> !a_oe && !b_oe) else $error("port driven while isolated");

	chk_b_live_drive: assert property (@(posedge clk_sys) disable iff (rst)
		ce && ctrl_pins.a_to_b_drive_enable && !ctrl_pins.b_side_source_select
		|=> b_oe && b_out == ~$past(a_in)) else $error("B live path wrong");

	chk_a_live_drive: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !ctrl_pins.b_to_a_drive_enable_n && !ctrl_pins.a_side_source_select
		|=> a_oe && a_out == ~$past(b_in)) else $error("A live path wrong");

	chk_b_stored_drive: assert property (@(posedge clk_sys) disable iff (rst)
		ce && ctrl_pins.a_to_b_drive_enable && ctrl_pins.b_side_source_select
		|=> b_out == ~$past(a_store_reg)) else $error("B stored path wrong");

	chk_a_stored_drive: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !ctrl_pins.b_to_a_drive_enable_n && ctrl_pins.a_side_source_select
		|=> a_out == ~$past(b_store_reg)) else $error("A stored path wrong");

	chk_oe_independent: assert property (@(posedge clk_sys) disable iff (rst)
		ce |=> b_oe == $past(ctrl_pins.a_to_b_drive_enable)
		&& a_oe == !$past(ctrl_pins.b_to_a_drive_enable_n)) else $error("drive enable crossed");

	chk_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
		ce && bus_req && wait_reg ##1 ce |-> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
endmodule

// file: common/ortx_pkg.sv
/*
 * shared constants and carrier types of the octal registered bus transceiver.
 * assumes a 32-bit avalon-mm slave with byte addresses and one aligned word per register.
 */
package ortx_pkg;
	// port width and log depth defaults
	localparam int ORTX_PORT_W = 8;
	localparam int ORTX_LOG_DEPTH = 4;
	// register byte offsets
	localparam logic [3:0] ORTX_CTRL_OFF = 4'h0;
	localparam logic [3:0] ORTX_STAT_OFF = 4'h4;
	localparam logic [3:0] ORTX_LOG_OFF = 4'h8;
	localparam logic [3:0] ORTX_STORE_OFF = 4'hc;
	// control field positions and reset value
	localparam int ORTX_CTRL_LOG_A_BIT = 0;
	localparam int ORTX_CTRL_LOG_B_BIT = 1;
	localparam logic [1:0] ORTX_CTRL_RST = 2'h0;
	// status field positions
	localparam int ORTX_STAT_OVF_BIT = 0;
	localparam int ORTX_STAT_NEMPTY_BIT = 1;
	localparam int ORTX_STAT_A_OE_BIT = 2;
	localparam int ORTX_STAT_B_OE_BIT = 3;
	localparam int ORTX_STAT_A_LIVE_POS = 8;
	localparam int ORTX_STAT_B_LIVE_POS = 16;
	// log word field positions
	localparam int ORTX_LOG_B_POS = 8;
	localparam int ORTX_LOG_A_HIT_BIT = 16;
	localparam int ORTX_LOG_B_HIT_BIT = 17;
	localparam int ORTX_LOG_VALID_BIT = 18;
	// store word field positions
	localparam int ORTX_STORE_B_POS = 8;

	// pin-level control of the transceiver
	typedef struct packed {
		logic a_to_b_drive_enable;
		logic b_to_a_drive_enable_n;
		logic b_side_source_select;
		logic a_side_source_select;
	} ortx_ctrl_t;

	// one capture event as kept in the log
	typedef struct packed {
		logic b_hit;
		logic a_hit;
		logic [ORTX_PORT_W-1:0] b_val;
		logic [ORTX_PORT_W-1:0] a_val;
	} ortx_log_t;
	localparam int ORTX_LOG_W = $bits(ortx_log_t);
endpackage

// file: sim/ortx_bus_model.sv
/*
 * far-side model of the two shared buses A and B around the transceiver.
 * assumes the bench commands the far drivers; a line nobody drives toggles every cycle.
 */
`timescale 1ns/1ps

module ortx_bus_model (
	// clock
	input wire logic clk_sys,
	// device drive
	input wire logic [7:0] a_out,
	input wire logic a_oe,
	input wire logic [7:0] b_out,
	input wire logic b_oe,
	// far drivers
	input wire logic pa_en,
	input wire logic [7:0] pa_val,
	input wire logic pb_en,
	input wire logic [7:0] pb_val,
	// resolved wires
	output logic [7:0] a_in,
	output logic [7:0] b_in
);
	logic [7:0] a_last_reg = 8'h00;
	logic [7:0] b_last_reg = 8'h00;

	// far driver first, then the device, else a floating pattern, never a stale value
	assign a_in = pa_en ? pa_val : (a_oe ? a_out : ~a_last_reg);
	assign b_in = pb_en ? pb_val : (b_oe ? b_out : ~b_last_reg);

	// last seen level, so released lines do not keep looking valid
	always_ff @(posedge clk_sys) begin
		a_last_reg <= a_in;
		b_last_reg <= b_in;
	end
endmodule

// file: sim/ortx_top_tb.sv
/*
 * self-checking bench for the transceiver, its capture log and its register bus.
 * assumes ortx_pkg is compiled first; ce is dropped only in the freeze scenario.
 */
`timescale 1ns/1ps

module ortx_top_tb;
	import ortx_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	ortx_ctrl_t ctrl = 4'h4;
	logic a_capture_clock = 1'b0;
	logic b_capture_clock = 1'b0;
	logic [7:0] a_in, b_in, a_out, b_out;
	logic a_oe, b_oe, log_ready, avs_waitrequest;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, d;
	logic pa_en = 1'b0;
	logic pb_en = 1'b0;
	logic [7:0] pa_val = 8'h00;
	logic [7:0] pb_val = 8'h00;
	int n_mismatch = 0;
	int n_checks = 0;

	always #20 clk_sys = ~clk_sys;

	ortx_top dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .ctrl_pins(ctrl),
		.a_capture_clock(a_capture_clock), .b_capture_clock(b_capture_clock),
		.a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
		.log_ready(log_ready), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	ortx_bus_model far_side (.clk_sys(clk_sys), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
		.b_oe(b_oe), .pa_en(pa_en), .pa_val(pa_val), .pb_en(pb_en), .pb_val(pb_val),
		.a_in(a_in), .b_in(b_in));

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// one avalon transfer; request held until waitrequest is seen low at an edge
	task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= ad;
		avs_writedata <= wd;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 100) check(1'b1, 1'b0, "bus answer");
		@(posedge clk_sys);
	endtask

	// one capture pulse, low again before the next one
	task automatic capture(input logic ca, input logic cb);
		a_capture_clock <= ca;
		b_capture_clock <= cb;
		cyc(1);
		a_capture_clock <= 1'b0;
		b_capture_clock <= 1'b0;
		cyc(3);
	endtask

	// far drivers and control pins together, then let the registered drive settle
	task automatic setup(input logic ae, input logic [7:0] av_, input logic be,
		input logic [7:0] bv, input logic [3:0] c);
		pa_en <= ae;
		pa_val <= av_;
		pb_en <= be;
		pb_val <= bv;
		ctrl <= c;
		cyc(3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_drive_modes();
		setup(1'b1, 8'h5a, 1'b1, 8'ha5, 4'h4);
		check({a_oe, b_oe}, 2'b00, "isolation");
		setup(1'b1, 8'h5a, 1'b0, 8'h00, 4'hc);
		check({a_oe, b_oe}, 2'b01, "b only");
		check(b_out, 8'ha5, "live a to b");
		av(1'b0, ORTX_STAT_OFF, 32'h0);
		check(d[23:2], {8'ha5, 8'h5a, 4'h0, 1'b1, 1'b0}, "status drive and live");
		setup(1'b0, 8'h00, 1'b1, 8'h3e, 4'h0);
		check({a_oe, b_oe}, 2'b10, "a only");
		check(a_out, 8'hc1, "live b to a");
	endtask

	task automatic t_stored();
		setup(1'b1, 8'h3c, 1'b1, 8'h81, 4'h4);
		capture(1'b1, 1'b0);
		capture(1'b0, 1'b1);
		pa_val <= 8'h77;
		cyc(2);
		av(1'b0, ORTX_STORE_OFF, 32'h0);
		check(d[15:0], 16'h813c, "store both, no edge");
		// capture while b is driven from the stored value
		setup(1'b1, 8'hc3, 1'b0, 8'h00, 4'he);
		capture(1'b1, 1'b0);
		check(b_out, 8'h3c, "stored a to b");
		setup(1'b0, 8'h00, 1'b0, 8'h00, 4'hb);
		check({a_oe, b_oe, a_out, b_out}, 18'h37e3c, "both stored");
		// staggered loads from the device's own drive
		capture(1'b1, 1'b0);
		capture(1'b0, 1'b1);
		av(1'b0, ORTX_STORE_OFF, 32'h0);
		check(d[15:0], 16'h817e, "own drive captured");
	endtask

	task automatic t_both_clocks();
		setup(1'b1, 8'h96, 1'b0, 8'h00, 4'hc);
		capture(1'b1, 1'b1);
		av(1'b0, ORTX_STORE_OFF, 32'h0);
		check(d[15:0], 16'h6996, "b takes driven b");
		setup(1'b0, 8'h00, 1'b1, 8'he1, 4'h0);
		capture(1'b1, 1'b1);
		av(1'b0, ORTX_STORE_OFF, 32'h0);
		check(d[15:0], 16'he11e, "a takes driven a");
	endtask

	task automatic t_hold();
		setup(1'b1, 8'h0f, 1'b0, 8'h00, 4'h8);
		setup(1'b0, 8'h00, 1'b0, 8'h00, 4'h8);
		cyc(3);
		check({a_in, b_in}, 16'h0ff0, "loop holds");
	endtask

	// clock enable low: drive, edge detectors and stores all freeze
	task automatic t_freeze();
		ce <= 1'b0;
		setup(1'b1, 8'h55, 1'b1, 8'haa, 4'h4);
		check({a_oe, b_oe, a_out, b_out}, 18'h30ff0, "frozen drive");
		capture(1'b1, 1'b1);
		ce <= 1'b1;
		cyc(2);
		check({a_oe, b_oe}, 2'b00, "drive after thaw");
		av(1'b0, ORTX_STORE_OFF, 32'h0);
		check(d[15:0], 16'he11e, "frozen store");
	endtask

	// fill the log past full, then drain it and clear the overflow
	task automatic t_log();
		setup(1'b1, 8'h10, 1'b0, 8'h00, 4'h4);
		av(1'b1, ORTX_CTRL_OFF, 32'h1);
		for (int i = 0; i < 5; i++) begin
			pa_val <= 8'h10 + 8'(i);
			cyc(1);
			capture(1'b1, 1'b0);
			if (i == 3) check(log_ready, 1'b0, "log full");
		end
		av(1'b0, ORTX_STAT_OFF, 32'h0);
		check(d[1:0], 2'b11, "overflow and non-empty");
		for (int i = 0; i < 4; i++) begin
			av(1'b0, ORTX_LOG_OFF, 32'h0);
			check({d[18:16], d[7:0]}, {3'b101, 8'h10 + 8'(i)}, "log entry");
		end
		av(1'b0, ORTX_STAT_OFF, 32'h0);
		check(d[1:0], 2'b01, "drained");
		av(1'b1, ORTX_STAT_OFF, 32'h1);
		av(1'b0, ORTX_STAT_OFF, 32'h0);
		check({log_ready, d[1:0]}, 3'b100, "overflow cleared");
		// port B logging alone
		setup(1'b0, 8'h00, 1'b1, 8'h4b, 4'h4);
		av(1'b1, ORTX_CTRL_OFF, 32'h2);
		capture(1'b0, 1'b1);
		av(1'b0, ORTX_LOG_OFF, 32'h0);
		check({d[18:16], d[15:8]}, {3'b110, 8'h4b}, "log B entry");
		av(1'b0, 4'h2, 32'h0);
		check(d, 32'h0, "unmapped read");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// verdict, sequence and watchdog
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		t_drive_modes();
		t_stored();
		t_both_clocks();
		t_hold();
		t_freeze();
		t_log();
		tally_and_finish();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		cyc(4000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
